// ==== test/sev_bus_master.sv ====
// Two-wire bus master model: drives the serial clock and open-drain data
`timescale 1ns/1ps
module sev_bus_master (
  // System clock paces the bus
  input wire logic sys_clk,
  // Bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // Idle bus: clock parked high, data released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // One bit; data moves mid-low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge sys_clk);
    sda_oe <= !b;
    repeat (3) @(posedge sys_clk);
    scl <= 1'b1;
    @(posedge sys_clk);
    r = sda;
    @(posedge sys_clk);
    scl <= 1'b0;
  endtask
  // Late clock rise lets a slave ack drop before the start edge
  task automatic start();
    @(posedge sys_clk);
    sda_oe <= 1'b0;
    repeat (6) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sda_oe <= 1'b1;
    repeat (3) @(posedge sys_clk);
    scl <= 1'b0;
  endtask
  // Stop only once the slave has let go of data
  task automatic stop();
    @(posedge sys_clk);
    sda_oe <= 1'b1;
    repeat (5) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sda_oe <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // Byte plus acknowledge slot; mack high means master acknowledges
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(!mack, a);
    ack = !a;
  endtask
endmodule // sev_bus_master

// ==== test/sev_checker.sv ====
// Port-level protocol checker for the serial slave, bound to its top
`timescale 1ns/1ps
module sev_checker #(
  parameter int unsigned NV_CYC = 200,
  parameter int unsigned WDT_CYC0 = 2000,
  parameter int unsigned WDT_CYC1 = 1500,
  parameter int unsigned WDT_CYC2 = 1000
) (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Bus
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  input wire logic sda_pin_out,
  input wire logic sda_pin_oe,
  // Straps and status
  input wire logic wp_pin,
  input wire logic [1:0] dev_sel_pin,
  input wire logic nv_busy,
  input wire logic watchdog_expired
);
  logic scl_d_q;
  logic sda_d_q;
  logic [31:0] busy_cnt_q;
  logic [31:0] idle_cnt_q;
  logic [3:0] stop_age_q;
  wire start_w = scl_pin && scl_d_q && sda_d_q && !sda_pin_in;
  wire stop_w = scl_pin && scl_d_q && !sda_d_q && sda_pin_in;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Pin history, busy length, time since start and since stop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      busy_cnt_q <= '0;
      idle_cnt_q <= '0;
      stop_age_q <= 4'hF;
    end else begin
      scl_d_q <= scl_pin;
      sda_d_q <= sda_pin_in;
      busy_cnt_q <= nv_busy ? busy_cnt_q + 32'h1 : 32'h0;
      idle_cnt_q <= start_w ? 32'h0 : idle_cnt_q + 32'h1;
      stop_age_q <= stop_w ? 4'h0 : (stop_age_q == 4'hF ? 4'hF : stop_age_q + 4'h1);
    end
  end
  AST_OUT_LOW: assert property (!sda_pin_out)
    else $error("data output not low");
  AST_OE_SCL_LOW: assert property ($changed(sda_pin_oe) |-> !scl_pin)
    else $error("data drive moved while clock high");
  AST_BUSY_QUIET: assert property (nv_busy |-> !sda_pin_oe)
    else $error("data driven during store");
  AST_BUSY_LEN: assert property ($fell(nv_busy) |-> busy_cnt_q == NV_CYC)
    else $error("store length wrong");
  AST_BUSY_IDLE_BUS: assert property ($rose(nv_busy) |-> scl_pin && sda_pin_in)
    else $error("store began on busy bus");
  AST_BUSY_AFTER_STOP: assert property ($rose(nv_busy) |-> stop_age_q < 4'h8)
    else $error("store began without stop");
  AST_WDT_EARLY: assert property ($rose(watchdog_expired) |-> idle_cnt_q >= WDT_CYC2)
    else $error("watchdog expired too early");
  AST_WDT_CLEAR: assert property (start_w |-> ##[1:8] !watchdog_expired)
    else $error("start did not clear watchdog");
endmodule // sev_checker
bind sev_slave sev_checker #(.NV_CYC(NV_CYC), .WDT_CYC0(WDT_CYC0), .WDT_CYC1(WDT_CYC1),
  .WDT_CYC2(WDT_CYC2)) chk (.sys_clk(sys_clk), .rst(rst), .scl_pin(scl_pin),
  .sda_pin_in(sda_pin_in), .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe),
  .wp_pin(wp_pin), .dev_sel_pin(dev_sel_pin), .nv_busy(nv_busy),
  .watchdog_expired(watchdog_expired));

// ==== test/sev_slave_test.sv ====
// Testbench for the serial slave: row table, then config, watchdog and faults
`timescale 1ns/1ps
module sev_slave_test;
  typedef struct {
    logic [15:0] a; logic [7:0] d; int n; logic ack; logic [15:0] ra; logic [7:0] rd;
  } sev_row_t;
  localparam logic [7:0] ADR = {sev_pkg::DEV_TYPE_ID, sev_pkg::DEV_FIXED_BIT, 2'h2, 1'b0};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_pin = 1'b0;
  logic [1:0] dev_sel_pin = 2'h2;
  logic sda_pin_out, sda_pin_oe, nv_busy, watchdog_expired, scl, m_oe, ok, k;
  logic [7:0] rx;
  logic [7:0] rbuf [0:7];
  int n_errors = 0;
  int num_checks = 0;
  wire sda = !(sda_pin_oe || m_oe);
  sev_row_t rows [4] = '{'{16'h0123, 8'h5A, 1, 1'b1, 16'h0123, 8'h5A},
    '{16'h0FFF, 8'hC3, 1, 1'b1, 16'h0FFF, 8'hC3}, '{16'h007C, 8'h10, 12, 1'b1, 16'h0040, 8'h14},
    '{16'h00C0, 8'h00, 66, 1'b1, 16'h00C1, 8'h41}};
  // Clock at 20 MHz
  always #25 sys_clk = ~sys_clk;
  sev_slave #(.NV_CYC(200), .WDT_CYC0(2000), .WDT_CYC1(1500), .WDT_CYC2(1000)) uut (
    .sys_clk(sys_clk), .rst(rst), .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe), .wp_pin(wp_pin), .dev_sel_pin(dev_sel_pin), .nv_busy(nv_busy),
    .watchdog_expired(watchdog_expired));
  sev_bus_master m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Start, device address and both word address bytes; ok is the and of acks
  task automatic hdr(input logic [15:0] a);
    m.start();
    m.xfer(ADR, 1'b0, rx, ok);
    for (int i = 0; i < 2; i++) begin
      m.xfer(i == 0 ? a[15:8] : a[7:0], 1'b0, rx, k);
      ok = ok & k;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
    hdr(a);
    for (int i = 0; i < n; i++) begin
      m.xfer(d + 8'(i), 1'b0, rx, k);
      ok = ok & k;
    end
    m.stop();
  endtask
  // Random read; the last byte is not acknowledged
  task automatic rd(input logic [15:0] a, input int n);
    hdr(a);
    m.start();
    m.xfer(ADR | 8'h01, 1'b0, rx, k);
    for (int i = 0; i < n; i++) m.xfer(8'hFF, i < n - 1, rbuf[i], k);
    m.stop();
  endtask
  // Bounded wait for the store to finish
  task automatic idle();
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 400 && nv_busy !== 1'b0; i++) @(posedge sys_clk);
    chk("store end", 8'h00, {7'h0, nv_busy});
  endtask
  task automatic cfg(input logic [7:0] b);
    wr(16'hFFFF, b, 1);
    idle();
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, about four times the expected run, under 100k cycles
  initial begin
    #4_000_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(16'hFFFF, 8'h02, 1);
    repeat (8) @(posedge sys_clk);
    chk("latch write busy", 8'h00, {7'h0, nv_busy});
    rd(16'hFFFF, 1);
    chk("cfg after 02", 8'h62, rbuf[0]);
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d, rows[r].n);
      chk("write ack", {7'h0, rows[r].ack}, {7'h0, ok});
      idle();
      rd(rows[r].ra, 1);
      chk("read back", rows[r].rd, rbuf[0]);
    end
    rd(16'h0040, 8);
    for (int i = 0; i < 8; i++) chk("stream", 8'h14 + 8'(i), rbuf[i]);
    $display("Test table done");
    cfg(8'h06);
    rd(16'hFFFF, 1);
    chk("cfg unlocked", 8'h66, rbuf[0]);
    cfg(8'h47);
    rd(16'hFFFF, 1);
    chk("cfg keep", 8'h66, rbuf[0]);
    cfg(8'h43);
    rd(16'hFFFF, 1);
    chk("cfg stored", 8'h41, rbuf[0] & 8'hFD);
    $display("Test config done");
    m.start();
    m.stop();
    repeat (950) @(posedge sys_clk);
    chk("wdt early", 8'h00, {7'h0, watchdog_expired});
    repeat (100) @(posedge sys_clk);
    chk("wdt expired", 8'h01, {7'h0, watchdog_expired});
    m.start();
    m.stop();
    chk("wdt cleared", 8'h00, {7'h0, watchdog_expired});
    $display("Test watchdog done");
    cfg(8'h02);
    wr(16'h0010, 8'h77, 1);
    chk("protected ack", 8'h00, {7'h0, ok});
    wr(16'h0200, 8'h33, 1);
    chk("open ack", 8'h01, {7'h0, ok});
    m.start();
    m.xfer(ADR, 1'b0, rx, k);
    m.stop();
    chk("poll while busy", 8'h00, {7'h0, k});
    idle();
    wr(16'hFFFF, 8'h02, 2);
    chk("second cfg byte", 8'h00, {7'h0, ok});
    hdr(16'h0200);
    repeat (4) m.bit_io(1'b0, k);
    m.stop();
    repeat (8) @(posedge sys_clk);
    chk("early stop busy", 8'h00, {7'h0, nv_busy});
    rd(16'h0200, 1);
    chk("early stop data", 8'h33, rbuf[0]);
    dev_sel_pin <= 2'h1;
    wr(16'h0300, 8'h11, 1);
    chk("wrong select", 8'h00, {7'h0, ok});
    dev_sel_pin <= 2'h2;
    wp_pin <= 1'b1;
    cfg(8'h06);
    cfg(8'hC3);
    cfg(8'h06);
    cfg(8'h3B);
    rd(16'hFFFF, 1);
    chk("hw protect", 8'hA3, rbuf[0]);
    cfg(8'h06);
    wr(16'h0010, 8'h77, 1);
    rd(16'hFFFF, 1);
    chk("unlock cleared", 8'hA3, rbuf[0]);
    cfg(8'h00);
    wr(16'h0300, 8'h11, 1);
    chk("latch cleared", 8'h00, {7'h0, ok});
    $display("Test faults done");
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(16'h0300, 8'h11, 1);
    chk("latch clear ack", 8'h00, {7'h0, ok});
    rd(16'hFFFF, 1);
    chk("cfg reset", 8'h60, rbuf[0]);
    $display("Test reset done");
    end_of_test();
  end
endmodule // sev_slave_test

// ==== verilog/sev_pkg.sv ====
// Constants, types and timing for the supervisor serial slave
// Overview of operation
// - Latch clear at reset blocks and nacks writes
// - Config 02 sets latch, 00 clears it
// - Latch-only writes start no nonvolatile cycle
// - Watchdog select: 1.4s, 600ms, 200ms, off
// - Hardware protect needs pin and enable high
// - Protected blocks and locked bits refuse writes
// - Protected array write gets no acknowledge
// - Third write stores settings, 10ms cycle
// - Cycle clears unlock; bit 2 keeps it
// - Second config data byte aborts with nack
// - Reads never disturb the unlock sequence
// - Unlock clears on store, reset, protected write
// - Data changes only while clock low
// - Nothing answered before a start condition
// - Stop ends transaction, device goes standby
// - Ack matching address, both word address bytes and each data byte that is allowed to be written
// - No ack for mismatched address byte
// - Read streams bytes while master acks
// - Stop after data starts write; bus ignored
// - Page write wraps inside 64-byte page
// - Config register lives at address FFFF
// - Early stop resets interface, no write
package sev_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned NV_CYCLE_MS = 10;
  localparam int unsigned NV_CYCLES = NV_CYCLE_MS * (CLK_HZ / 1000);
  localparam int unsigned WDT_SEL0_MS = 1400;
  localparam int unsigned WDT_SEL1_MS = 600;
  localparam int unsigned WDT_SEL2_MS = 200;
  localparam int unsigned WDT_SEL0_CYCLES = WDT_SEL0_MS * (CLK_HZ / 1000);
  localparam int unsigned WDT_SEL1_CYCLES = WDT_SEL1_MS * (CLK_HZ / 1000);
  localparam int unsigned WDT_SEL2_CYCLES = WDT_SEL2_MS * (CLK_HZ / 1000);

  // Sizes
  localparam int unsigned ARRAY_BYTES = 4096;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned FIFO_DEPTH = 16;

  // Addressing and commands
  localparam logic [15:0] CFG_ADDR = 16'hFFFF;
  localparam logic [3:0] DEV_TYPE_ID = 4'hA;
  localparam logic DEV_FIXED_BIT = 1'b0;
  localparam logic [7:0] CMD_SET_WEL = 8'h02;
  localparam logic [7:0] CMD_SET_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_CLR_WEL = 8'h00;
  localparam logic [1:0] NV_STORE_TAG = 2'h1;
  localparam logic [1:0] NV_KEEP_TAG = 2'h3;

  // Protected range ends, exclusive
  localparam logic [11:0] PROT_END_1PG = 12'h040;
  localparam logic [11:0] PROT_END_2PG = 12'h080;
  localparam logic [11:0] PROT_END_4PG = 12'h100;
  localparam logic [11:0] PROT_END_8PG = 12'h200;

  // Factory values of the nonvolatile bits, and the watchdog off code
  localparam logic [1:0] WD_SEL_RST = 2'h3;
  localparam logic [2:0] BP_RST = 3'h0;
  localparam logic HWPE_RST = 1'b0;
  localparam logic [1:0] WD_SEL_OFF = 2'h3;

  // Register layout, bit 7 down to bit 0
  typedef struct packed {
    logic hw_protect_enable;
    logic watchdog_period_sel_hi;
    logic watchdog_period_sel_lo;
    logic array_protect_sel_1;
    logic array_protect_sel_0;
    logic config_unlock_latch;
    logic write_enable_latch;
    logic array_protect_sel_2;
  } sev_cfg_t;

  typedef enum logic [1:0] {ROLE_DEV, ROLE_AHI, ROLE_ALO, ROLE_DATA} sev_role_t;
  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} sev_state_t;

endpackage

// ==== verilog/sev_slave.sv ====
// Read-ahead FIFO and the serial slave front end with array and watchdog
`timescale 1ns/1ps

// Byte FIFO with flush; read prefetch buffer
module sev_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [0:DEPTH-1];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Honest flags from the occupancy count
  assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_q != '0);
  assign out_data = buf_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      buf_q[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sev_fifo

// Serial slave with write latches, protection, page writes and watchdog
module sev_slave #(
  parameter int unsigned NV_CYC = sev_pkg::NV_CYCLES,
  parameter int unsigned WDT_CYC0 = sev_pkg::WDT_SEL0_CYCLES,
  parameter int unsigned WDT_CYC1 = sev_pkg::WDT_SEL1_CYCLES,
  parameter int unsigned WDT_CYC2 = sev_pkg::WDT_SEL2_CYCLES
) (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Serial bus, open drain data
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  // Straps and protect pin
  input wire logic wp_pin,
  input wire logic [1:0] dev_sel_pin,
  // Status
  output logic nv_busy,
  output logic watchdog_expired
);
  // Pin synchronisers and edge history
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, wp_m, wp_s;
  logic [1:0] sel_m, sel_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  // Bus engine
  sev_pkg::sev_state_t state_q;
  sev_pkg::sev_role_t role_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rw_q, mack_q, abort_q, alo_done_q, sda_oe_q;
  logic [1:0] dcnt_q;
  logic [15:0] addr_q, rd_addr_q, pf_ptr_q;
  logic [7:0] cfg_byte_q;
  logic [7:0] page_q [0:sev_pkg::PAGE_BYTES-1];
  logic [sev_pkg::PAGE_BYTES-1:0] valid_q;
  // Array, register, nonvolatile cycle
  logic [7:0] mem_q [0:sev_pkg::ARRAY_BYTES-1];
  sev_pkg::sev_cfg_t cfg_q;
  logic busy_q, copy_q;
  logic [6:0] copy_idx_q;
  logic [31:0] nv_cnt_q, wd_cnt_q, wd_limit;
  logic wd_exp_q;
  // Decisions
  logic rx_ack, prot_hit, byte_done, tx_load, commit, commit_arr;
  logic cfg_nv, cfg_keep, hw_prot;
  logic [2:0] bp;
  logic fifo_flush, fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_in_data, fifo_out_data;

  // Two flops on every outside input; clock and data keep a third for edge history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
      {wp_m, wp_s} <= 2'h0;
      {sel_m, sel_s} <= 4'h0;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_pin_in, sda_m, sda_s};
      {wp_m, wp_s} <= {wp_pin, wp_m};
      {sel_m, sel_s} <= {dev_sel_pin, sel_m};
    end
  end

  // Bus events; data moving while clock high is start or stop
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  assign start_det = scl_s && scl_p && sda_p && !sda_s;
  assign stop_det = scl_s && scl_p && !sda_p && sda_s;

  assign bp = {cfg_q.array_protect_sel_2, cfg_q.array_protect_sel_1, cfg_q.array_protect_sel_0};
  assign hw_prot = wp_s && cfg_q.hw_protect_enable;

  // Block protect decode
  function automatic logic blk_prot(input logic [2:0] sel, input logic [11:0] a);
    logic r;
    r = 1'b0;
    case (sel)
      3'h3: r = 1'b1;
      3'h4: r = a < sev_pkg::PROT_END_1PG;
      3'h5: r = a < sev_pkg::PROT_END_2PG;
      3'h6: r = a < sev_pkg::PROT_END_4PG;
      3'h7: r = a < sev_pkg::PROT_END_8PG;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Acknowledge decision for the byte just received
  always_comb begin
    rx_ack = 1'b0;
    prot_hit = 1'b0;
    unique case (role_q)
      sev_pkg::ROLE_DEV: begin
        rx_ack = (sh_q[7:1] == {sev_pkg::DEV_TYPE_ID, sev_pkg::DEV_FIXED_BIT, sel_s});
      end
      sev_pkg::ROLE_AHI, sev_pkg::ROLE_ALO: begin
        rx_ack = 1'b1;
      end
      sev_pkg::ROLE_DATA: begin
        if (abort_q) begin
          rx_ack = 1'b0;
        end else if (addr_q == sev_pkg::CFG_ADDR) begin
          // Only the very first byte; latch-set command passes with latch clear
          rx_ack = (dcnt_q == 2'h0) &&
                   (cfg_q.write_enable_latch || sh_q == sev_pkg::CMD_SET_WEL);
        end else if (!cfg_q.write_enable_latch) begin
          rx_ack = 1'b0;
        end else if (blk_prot(bp, addr_q[11:0])) begin
          prot_hit = 1'b1;
        end else begin
          rx_ack = 1'b1;
        end
      end
    endcase
  end

  assign byte_done = (state_q == sev_pkg::ST_RX) && scl_fall && (bit_q == 4'h8)
                     && !start_det && !stop_det;
  // Role has already moved on to the high address byte when the address ack ends
  assign tx_load = !start_det && !stop_det && scl_fall &&
                   (((state_q == sev_pkg::ST_ACK) && (role_q == sev_pkg::ROLE_AHI) && rw_q) ||
                    ((state_q == sev_pkg::ST_MACK) && mack_q));
  // Write only after a whole acked byte; the stop's own clock pulse counts one bit
  assign commit = stop_det && (state_q == sev_pkg::ST_RX) && (bit_q <= 4'h1) &&
                  (role_q == sev_pkg::ROLE_DATA) && (dcnt_q != 2'h0) && !abort_q;
  assign commit_arr = commit && (addr_q != sev_pkg::CFG_ADDR);
  assign cfg_nv = commit && (addr_q == sev_pkg::CFG_ADDR) && cfg_q.config_unlock_latch &&
                  (cfg_byte_q[2:1] == sev_pkg::NV_STORE_TAG);
  assign cfg_keep = cfg_q.config_unlock_latch && (cfg_byte_q[2:1] == sev_pkg::NV_KEEP_TAG);

  // Bus engine; while busy a start is ignored so nothing answers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= sev_pkg::ST_IDLE;
      role_q <= sev_pkg::ROLE_DEV;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      abort_q <= 1'b0;
      alo_done_q <= 1'b0;
      dcnt_q <= 2'h0;
      addr_q <= 16'h0000;
      rd_addr_q <= 16'h0000;
      cfg_byte_q <= 8'h00;
      valid_q <= '0;
      sda_oe_q <= 1'b0;
    end else begin
      alo_done_q <= 1'b0;
      if (start_det && !busy_q) begin
        state_q <= sev_pkg::ST_RX;
        role_q <= sev_pkg::ROLE_DEV;
        bit_q <= 4'h0;
        abort_q <= 1'b0;
        dcnt_q <= 2'h0;
        valid_q <= '0;
        sda_oe_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= sev_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          sev_pkg::ST_IDLE: sda_oe_q <= 1'b0;
          sev_pkg::ST_RX: begin
            if (scl_rise && bit_q != 4'h8) begin
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            if (byte_done) begin
              // Nack drops to idle until the next start
              state_q <= rx_ack ? sev_pkg::ST_ACK : sev_pkg::ST_IDLE;
              sda_oe_q <= rx_ack;
              if (role_q == sev_pkg::ROLE_DATA && !rx_ack) begin
                abort_q <= 1'b1;
              end
              unique case (role_q)
                sev_pkg::ROLE_DEV: begin
                  rw_q <= sh_q[0];
                  role_q <= sev_pkg::ROLE_AHI;
                end
                sev_pkg::ROLE_AHI: begin
                  addr_q[15:8] <= sh_q;
                  role_q <= sev_pkg::ROLE_ALO;
                end
                sev_pkg::ROLE_ALO: begin
                  addr_q[7:0] <= sh_q;
                  rd_addr_q <= {addr_q[15:8], sh_q};
                  alo_done_q <= 1'b1;
                  role_q <= sev_pkg::ROLE_DATA;
                end
                sev_pkg::ROLE_DATA: begin
                  if (rx_ack) begin
                    dcnt_q <= (dcnt_q == 2'h3) ? dcnt_q : dcnt_q + 2'h1;
                    if (addr_q == sev_pkg::CFG_ADDR) begin
                      cfg_byte_q <= sh_q;
                    end else begin
                      // Low six bits wrap; later bytes overwrite in order
                      page_q[addr_q[5:0]] <= sh_q;
                      valid_q[addr_q[5:0]] <= 1'b1;
                      addr_q[5:0] <= addr_q[5:0] + 6'h01;
                      rd_addr_q <= {addr_q[15:6], addr_q[5:0] + 6'h01};
                    end
                  end
                end
              endcase
            end
          end
          sev_pkg::ST_ACK: begin
            if (tx_load) begin
              state_q <= sev_pkg::ST_TX;
            end else if (scl_fall) begin
              sda_oe_q <= 1'b0;
              state_q <= sev_pkg::ST_RX;
              bit_q <= 4'h0;
            end
          end
          sev_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_q == 4'h7) begin
                sda_oe_q <= 1'b0;
                state_q <= sev_pkg::ST_MACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_q <= !sh_q[6];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          sev_pkg::ST_MACK: begin
            if (scl_rise) begin
              mack_q <= !sda_s;
            end
            if (scl_fall && !mack_q) begin
              state_q <= sev_pkg::ST_IDLE;
            end
          end
        endcase
        // Load next byte on the falling edge so data moves with clock low
        if (tx_load) begin
          sh_q <= fifo_out_valid ? fifo_out_data : 8'hFF;
          sda_oe_q <= fifo_out_valid ? !fifo_out_data[7] : 1'b0;
          bit_q <= 4'h0;
          rd_addr_q <= (rd_addr_q == sev_pkg::CFG_ADDR || rd_addr_q[11:0] == 12'hFFF) ?
                       16'h0000 : rd_addr_q + 16'h0001;
          state_q <= sev_pkg::ST_TX;
        end
      end
    end
  end

  // Prefetch ahead of the reader; full FIFO stalls it
  assign fifo_flush = start_det || stop_det || alo_done_q;
  assign fifo_in_data = (pf_ptr_q == sev_pkg::CFG_ADDR) ? cfg_q : mem_q[pf_ptr_q[11:0]];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pf_ptr_q <= 16'h0000;
    end else if (fifo_flush) begin
      pf_ptr_q <= rd_addr_q;
    end else if (fifo_in_ready) begin
      pf_ptr_q <= (pf_ptr_q == sev_pkg::CFG_ADDR || pf_ptr_q[11:0] == 12'hFFF) ?
                  16'h0000 : pf_ptr_q + 16'h0001;
    end
  end

  sev_fifo #(
    .WIDTH(8),
    .DEPTH(sev_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .clk(sys_clk),
    .rst(rst),
    .flush(fifo_flush),
    .in_valid(1'b1),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(tx_load),
    .out_data(fifo_out_data)
  );

  // Register; reads never touch the latches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= {sev_pkg::HWPE_RST, sev_pkg::WD_SEL_RST, sev_pkg::BP_RST[1:0], 1'b0, 1'b0,
                sev_pkg::BP_RST[2]};
    end else if (byte_done && prot_hit) begin
      cfg_q.config_unlock_latch <= 1'b0;
    end else if (cfg_nv) begin
      {cfg_q.watchdog_period_sel_hi, cfg_q.watchdog_period_sel_lo} <= cfg_byte_q[6:5];
      if (!hw_prot) begin
        cfg_q.hw_protect_enable <= cfg_byte_q[7];
        cfg_q.array_protect_sel_2 <= cfg_byte_q[0];
        {cfg_q.array_protect_sel_1, cfg_q.array_protect_sel_0} <= cfg_byte_q[4:3];
      end
      cfg_q.config_unlock_latch <= 1'b0;
    end else if (commit && addr_q == sev_pkg::CFG_ADDR && !cfg_keep) begin
      // Volatile updates only; no busy period follows
      if (cfg_byte_q == sev_pkg::CMD_SET_WEL) begin
        cfg_q.write_enable_latch <= 1'b1;
      end else if (cfg_byte_q == sev_pkg::CMD_SET_UNLOCK && cfg_q.write_enable_latch) begin
        cfg_q.config_unlock_latch <= 1'b1;
        cfg_q.write_enable_latch <= 1'b1;
      end else if (cfg_byte_q == sev_pkg::CMD_CLR_WEL) begin
        cfg_q.write_enable_latch <= 1'b0;
      end
    end
  end

  // Nonvolatile cycle: copy the page in the first 64 cycles, busy for the full time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      copy_q <= 1'b0;
      copy_idx_q <= 7'h00;
      nv_cnt_q <= 32'h0000_0000;
    end else if (commit_arr || cfg_nv) begin
      busy_q <= 1'b1;
      copy_q <= commit_arr;
      copy_idx_q <= 7'h00;
      nv_cnt_q <= 32'h0000_0000;
    end else if (busy_q) begin
      if (copy_idx_q == 7'(sev_pkg::PAGE_BYTES - 1)) begin
        copy_q <= 1'b0;
      end
      copy_idx_q <= copy_idx_q + 7'h01;
      nv_cnt_q <= nv_cnt_q + 32'h0000_0001;
      if (nv_cnt_q >= NV_CYC - 1) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Array write port; only bytes loaded in this transaction change
  always_ff @(posedge sys_clk) begin
    if (copy_q && valid_q[copy_idx_q[5:0]]) begin
      mem_q[{addr_q[11:6], copy_idx_q[5:0]}] <= page_q[copy_idx_q[5:0]];
    end
  end

  // Watchdog period from the select bits; any start restarts it
  always_comb begin
    unique case ({cfg_q.watchdog_period_sel_hi, cfg_q.watchdog_period_sel_lo})
      2'h0: wd_limit = WDT_CYC0;
      2'h1: wd_limit = WDT_CYC1;
      2'h2: wd_limit = WDT_CYC2;
      2'h3: wd_limit = 32'hFFFF_FFFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_cnt_q <= 32'h0000_0000;
      wd_exp_q <= 1'b0;
    end else if (start_det || {cfg_q.watchdog_period_sel_hi, cfg_q.watchdog_period_sel_lo}
                 == sev_pkg::WD_SEL_OFF) begin
      wd_cnt_q <= 32'h0000_0000;
      wd_exp_q <= 1'b0;
    end else if (wd_cnt_q >= wd_limit - 32'h0000_0001) begin
      wd_exp_q <= 1'b1;
    end else begin
      wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
    end
  end

  // Outputs straight from flops; data pin only ever pulls low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sda_pin_out <= 1'b0;
      sda_pin_oe <= 1'b0;
      nv_busy <= 1'b0;
      watchdog_expired <= 1'b0;
    end else begin
      sda_pin_out <= 1'b0;
      sda_pin_oe <= sda_oe_q && !busy_q;
      nv_busy <= busy_q;
      watchdog_expired <= wd_exp_q;
    end
  end
endmodule // sev_slave
